// ===== bench/lsms_conv_model.sv
`timescale 1ns/10ps
module lsms_conv_model
  import lsms_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire lsms_pkg::lsms_conv_req_s conv_req,
  output lsms_pkg::lsms_conv_done_s conv_done,
  output logic [15:0] last_data
);
  logic [7:0] seq;
  logic [3:0] wait_cnt;
  logic busy;
  logic [2:0] chan;
  always @(posedge clk) begin
    conv_done.done <= 1'b0;
    // data toggles outside the done cycle so a late sample never sees a stale result
    conv_done.data <= ~conv_done.data;
    if (srst) begin
      conv_done <= '0;
      busy <= 1'b0;
      seq <= 8'h00;
      wait_cnt <= 4'h0;
      chan <= 3'h0;
      last_data <= 16'h0000;
    end else if (conv_req.valid === 1'b1) begin
      busy <= 1'b1;
      chan <= conv_req.chan;
      // alternate quick and slow answers
      wait_cnt <= seq[0] ? 4'h5 : 4'h0;
    end else if (busy && wait_cnt == 4'h0) begin
      busy <= 1'b0;
      seq <= seq + 8'h01;
      conv_done.done <= 1'b1;
      conv_done.chan <= chan;
      conv_done.data <= {seq, 5'h00, chan};
      last_data <= {seq, 5'h00, chan};
    end else if (busy) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule // lsms_conv_model

// ===== bench/lsms_sequencer_tb.sv
`timescale 1ns/10ps
module lsms_sequencer_tb;
  import lsms_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic bus_reset = 1'b0;
  logic cmd_write = 1'b0;
  logic irq_clear = 1'b0;
  logic prox_irq_enable = 1'b1;
  logic amb_irq_enable = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] wake_interval = 8'h00;
  logic [7:0] channel_enable_list = 8'h07;
  logic [7:0] unlock_code_reg = 8'h00;
  lsms_conv_req_s conv_req;
  lsms_conv_done_s conv_done;
  logic [15:0] result [7];
  logic [15:0] last_data;
  logic [7:0] response;
  logic [2:0] mode;
  logic regs_ready;
  logic unlocked;
  logic irq_o;
  logic irq_oe;
  logic [3:0] chq [$];
  logic [7:0] loop_codes [3] = '{CMD_LOOP_PROXIMITY, CMD_LOOP_AMBIENT, CMD_LOOP_BOTH};
  logic [3:0] loop_first [3] = '{4'h8, 4'hc, 4'h8};
  int err_count = 0;
  int checked = 0;
  logic [15:0] poll_val;
  int polls;
  int hits;
  always #4 clk = ~clk;
  lsms_sequencer #(.INIT_CYCLES_P(10)) uut (.clk(clk), .srst(srst), .bus_reset(bus_reset),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .wake_interval(wake_interval),
    .channel_enable_list(channel_enable_list), .unlock_code_reg(unlock_code_reg),
    .prox_irq_enable(prox_irq_enable), .amb_irq_enable(amb_irq_enable), .irq_clear(irq_clear),
    .conv_req(conv_req), .conv_done(conv_done), .result(result), .response(response), .mode(mode),
    .regs_ready(regs_ready), .unlocked(unlocked), .irq_o(irq_o), .irq_oe(irq_oe));
  lsms_conv_model conv (.clk(clk), .srst(srst), .conv_req(conv_req), .conv_done(conv_done),
    .last_data(last_data));
  // marker bit keeps channel 0 distinct from an empty slot
  always @(posedge clk) if (conv_req.valid === 1'b1) chq.push_back({1'b1, conv_req.chan});
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_standby();
    int n;
    n = 0;
    while (mode !== LSMS_STANDBY && n < 500) begin
      tick(1);
      n++;
    end
    chk(32'(mode), 32'(LSMS_STANDBY));
  endtask
  task automatic cmd(input logic [7:0] code);
    @(posedge clk);
    cmd_code <= code;
    cmd_write <= 1'b1;
    @(posedge clk);
    cmd_write <= 1'b0;
    tick(3);
    wait_standby();
    tick(4);
  endtask
  task automatic chk_seq(input logic [23:0] exp);
    logic [23:0] s;
    s = '0;
    foreach (chq[i]) s = {s[19:0], chq[i]};
    chk({8'h0, s}, {8'h0, exp});
    chq.delete();
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  initial begin
    tick(2);
    chk(32'(mode), 32'(LSMS_OFF));
    @(posedge clk);
    srst <= 1'b0;
    tick(1);
    chk(32'(mode), 32'(LSMS_INIT));
    wait_standby();
    $display("test reset done");
    // host stays quiet during initialization and unlocks only now
    @(posedge clk);
    unlock_code_reg <= UNLOCK_KEY_VALUE;
    tick(100);
    chk({31'h0, unlocked}, 32'h1);
    chk(32'(chq.size()), 32'h0);
    chk(32'(mode), 32'(LSMS_STANDBY));
    chk({31'h0, regs_ready}, 32'h1);
    $display("test standby done");
    cmd(CMD_NOP);
    chk({24'h0, response}, 32'h0);
    cmd(CMD_SINGLE_PROXIMITY);
    chk_seq(24'h00089a);
    chk({16'h0, result[2]}, {16'h0, last_data});
    chk({24'h0, response}, 32'h1);
    chk({30'h0, irq_o, irq_oe}, 32'h1);
    tick(20);
    chk({31'h0, irq_oe}, 32'h1);
    @(posedge clk);
    irq_clear <= 1'b1;
    @(posedge clk);
    irq_clear <= 1'b0;
    tick(2);
    chk({31'h0, irq_oe}, 32'h0);
    @(posedge clk);
    channel_enable_list <= 8'h77;
    prox_irq_enable <= 1'b0;
    cmd(CMD_SINGLE_AMBIENT);
    chk_seq(24'h000cde);
    chk({16'h0, result[6]}, {16'h0, last_data});
    chk({31'h0, irq_oe}, 32'h0);
    chk({24'h0, response}, 32'h2);
    @(posedge clk);
    amb_irq_enable <= 1'b1;
    cmd(CMD_SINGLE_BOTH);
    chk_seq(24'h89acde);
    chk({31'h0, irq_oe}, 32'h1);
    @(posedge clk);
    channel_enable_list <= 8'h01;
    for (int i = 0; i < 14; i++) cmd(CMD_SINGLE_PROXIMITY);
    chk({24'h0, response}, 32'h1);
    chq.delete();
    $display("test forced done");
    // rates are set before any loop command is issued
    @(posedge clk);
    wake_interval <= 8'h02;
    channel_enable_list <= 8'h11;
    for (int i = 0; i < 3; i++) begin
      cmd(loop_codes[i]);
      chq.delete();
      poll_val = result[loop_first[i][2:0]];
      polls = 0;
      // poll four times per wake so no result slips by unseen
      for (int p = 0; p < 20; p++) begin
        tick(15);
        if (result[loop_first[i][2:0]] !== poll_val) polls++;
        poll_val = result[loop_first[i][2:0]];
      end
      hits = 0;
      foreach (chq[k]) if (chq[k] == loop_first[i]) hits++;
      chk(32'(chq.size() >= 3), 32'h1);
      chk(32'(polls), 32'(hits));
      chk({28'h0, chq[0]}, {28'h0, loop_first[i]});
      cmd(CMD_SOFT_RESET);
      chq.delete();
    end
    $display("test autonomous done");
    @(posedge clk);
    wake_interval <= 8'h00;
    bus_reset <= 1'b1;
    @(posedge clk);
    bus_reset <= 1'b0;
    tick(1);
    chk(32'(mode inside {LSMS_OFF, LSMS_INIT}), 32'h1);
    wait_standby();
    tick(100);
    chk(32'(chq.size()), 32'h0);
    $display("test bus reset done");
    wrap_up();
  end
endmodule // lsms_sequencer_tb

// ===== logic/lsms_pkg.sv
package lsms_pkg;

  // command codes written by the host
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h01;
  localparam logic [7:0] CMD_SINGLE_PROXIMITY = 8'h05;
  localparam logic [7:0] CMD_SINGLE_AMBIENT = 8'h06;
  localparam logic [7:0] CMD_SINGLE_BOTH = 8'h07;
  localparam logic [7:0] CMD_LOOP_PROXIMITY = 8'h0d;
  localparam logic [7:0] CMD_LOOP_AMBIENT = 8'h0e;
  localparam logic [7:0] CMD_LOOP_BOTH = 8'h0f;

  // channel_enable_list bit positions
  localparam int CH_REFLECT_ONE = 0;
  localparam int CH_REFLECT_TWO = 1;
  localparam int CH_REFLECT_THREE = 2;
  localparam int CH_VISIBLE = 4;
  localparam int CH_INFRARED = 5;
  localparam int CH_AUX = 6;

  localparam logic [7:0] UNLOCK_KEY_VALUE = 8'h17;

  // timing: startup sequence length and wake interval unit
  localparam int INIT_TIME_US = 25;
  localparam int CLK_MHZ = 125;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  localparam int RATE_UNIT_NS = 256;
  localparam int RATE_UNIT_CYCLES = (RATE_UNIT_NS + 7) / 8;

  localparam logic [3:0] RESP_RESET = 4'h0;

  typedef enum logic [2:0] {
    LSMS_OFF,
    LSMS_INIT,
    LSMS_STANDBY,
    LSMS_PROX,
    LSMS_AMB
  } lsms_state_e;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
  } lsms_conv_req_s;

  typedef struct packed {
    logic done;
    logic [2:0] chan;
    logic [15:0] data;
  } lsms_conv_done_s;

endpackage

// ===== logic/lsms_sequencer.sv
`timescale 1ns/10ps
module lsms_sequencer #(
  parameter int INIT_CYCLES_P = lsms_pkg::INIT_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic bus_reset,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] wake_interval,
  input wire logic [7:0] channel_enable_list,
  input wire logic [7:0] unlock_code_reg,
  input wire logic prox_irq_enable,
  input wire logic amb_irq_enable,
  input wire logic irq_clear,
  output lsms_pkg::lsms_conv_req_s conv_req,
  input wire lsms_pkg::lsms_conv_done_s conv_done,
  output logic [15:0] result [7],
  output logic [7:0] response,
  output logic [2:0] mode,
  output logic regs_ready,
  output logic unlocked,
  output logic irq_o,
  output logic irq_oe
);
  import lsms_pkg::*;

  localparam int INIT_W = $clog2(INIT_CYCLES_P + 1);

  lsms_state_e state;
  logic [INIT_W-1:0] init_cnt;
  logic [2:0] want_prox;
  logic [2:0] want_amb;
  logic [2:0] todo_prox;
  logic [2:0] todo_amb;
  logic loop_prox;
  logic loop_amb;
  logic [7:0] tick_cnt;
  logic [7:0] rate_cnt;
  logic rate_tick;
  logic wake_periodic;
  logic cmd_done;
  logic irq_pend;
  logic [2:0] busy_chan;
  logic busy;

  wire soft_reset = cmd_write && cmd_code == CMD_SOFT_RESET;
  wire in_standby = state == LSMS_STANDBY;

  function automatic logic [2:0] first_set(input logic [2:0] v);
    if (v[0]) return 3'h1;
    if (v[1]) return 3'h2;
    if (v[2]) return 3'h4;
    return 3'h0;
  endfunction

  function automatic logic [2:0] bit_index(input logic [2:0] onehot, input logic [2:0] base);
    if (onehot[0]) return base;
    if (onehot[1]) return 3'(base + 3'h1);
    return 3'(base + 3'h2);
  endfunction

  // main mode machine
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= LSMS_OFF;
      init_cnt <= '0;
    end else if (bus_reset || soft_reset) begin
      state <= LSMS_OFF;
      init_cnt <= '0;
    end else begin
      unique case (state)
        LSMS_OFF: begin
          state <= LSMS_INIT;
        end
        LSMS_INIT: begin
          if (init_cnt == INIT_W'(INIT_CYCLES_P - 1)) begin
            state <= LSMS_STANDBY;
          end
          init_cnt <= init_cnt + 1'b1;
        end
        LSMS_STANDBY: begin
          // only a command, the periodic wake or a bus reset leaves sleep
          if (todo_prox != 3'h0) begin
            state <= LSMS_PROX;
          end else if (todo_amb != 3'h0) begin
            state <= LSMS_AMB;
          end
        end
        LSMS_PROX: begin
          if (todo_prox == 3'h0 && !busy) begin
            state <= (todo_amb != 3'h0) ? LSMS_AMB : LSMS_STANDBY;
          end
        end
        LSMS_AMB: begin
          if (todo_amb == 3'h0 && !busy) begin
            state <= LSMS_STANDBY;
          end
        end
      endcase
    end
  end

  assign want_prox = channel_enable_list[CH_REFLECT_THREE:CH_REFLECT_ONE];
  assign want_amb = channel_enable_list[CH_AUX:CH_VISIBLE];

  // loop flags set by loop commands, cleared by reset
  always_ff @(posedge clk) begin
    if (srst || bus_reset || soft_reset || state == LSMS_OFF) begin
      loop_prox <= 1'b0;
      loop_amb <= 1'b0;
    end else if (cmd_write && in_standby) begin
      if (cmd_code == CMD_LOOP_PROXIMITY || cmd_code == CMD_LOOP_BOTH) begin
        loop_prox <= 1'b1;
      end
      if (cmd_code == CMD_LOOP_AMBIENT || cmd_code == CMD_LOOP_BOTH) begin
        loop_amb <= 1'b1;
      end
    end
  end

  // wake interval timer: rate_tick is a slow enable, zero interval disables
  always_ff @(posedge clk) begin
    if (srst || wake_interval == 8'h00 || !(loop_prox || loop_amb)) begin
      tick_cnt <= '0;
      rate_cnt <= '0;
      rate_tick <= 1'b0;
    end else begin
      rate_tick <= tick_cnt == 8'(RATE_UNIT_CYCLES - 1);
      tick_cnt <= (tick_cnt == 8'(RATE_UNIT_CYCLES - 1)) ? 8'h0 : tick_cnt + 8'h1;
      if (rate_tick) begin
        rate_cnt <= (rate_cnt == wake_interval - 8'h1) ? 8'h0 : rate_cnt + 8'h1;
      end
    end
  end

  assign wake_periodic = rate_tick && rate_cnt == wake_interval - 8'h1 && wake_interval != 8'h00;

  // pending channel lists; a new wake only lands while asleep
  always_ff @(posedge clk) begin
    if (srst || bus_reset || soft_reset || state == LSMS_OFF || state == LSMS_INIT) begin
      todo_prox <= 3'h0;
      todo_amb <= 3'h0;
    end else if (in_standby) begin
      if (cmd_write) begin
        if (cmd_code == CMD_SINGLE_PROXIMITY || cmd_code == CMD_SINGLE_BOTH) begin
          todo_prox <= want_prox[2:0];
        end
        if (cmd_code == CMD_SINGLE_AMBIENT || cmd_code == CMD_SINGLE_BOTH) begin
          todo_amb <= want_amb[2:0];
        end
      end else if (wake_periodic) begin
        todo_prox <= loop_prox ? want_prox[2:0] : 3'h0;
        todo_amb <= loop_amb ? want_amb[2:0] : 3'h0;
      end
    end else if (!busy) begin
      if (state == LSMS_PROX && todo_prox != 3'h0) begin
        todo_prox <= todo_prox & ~first_set(todo_prox);
      end else if (state == LSMS_AMB && todo_amb != 3'h0) begin
        todo_amb <= todo_amb & ~first_set(todo_amb);
      end
    end else if (conv_done.done) begin
      // hold until the converter reports back
    end
  end

  // conversion request issue and tracking
  always_ff @(posedge clk) begin
    if (srst || state == LSMS_OFF) begin
      busy <= 1'b0;
      busy_chan <= 3'h0;
      conv_req <= '0;
    end else begin
      conv_req.valid <= 1'b0;
      if (!busy && state == LSMS_PROX && todo_prox != 3'h0) begin
        busy <= 1'b1;
        busy_chan <= bit_index(first_set(todo_prox), 3'h0);
        conv_req.valid <= 1'b1;
        conv_req.chan <= bit_index(first_set(todo_prox), 3'h0);
      end else if (!busy && state == LSMS_AMB && todo_amb != 3'h0) begin
        busy <= 1'b1;
        busy_chan <= bit_index(first_set(todo_amb), 3'h4);
        conv_req.valid <= 1'b1;
        conv_req.chan <= bit_index(first_set(todo_amb), 3'h4);
      end else if (busy && conv_done.done) begin
        busy <= 1'b0;
      end
    end
  end

  // result registers hold across standby
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 7; i++) begin
        result[i] <= 16'h0;
      end
    end else if (busy && conv_done.done) begin
      result[busy_chan] <= conv_done.data;
    end
  end

  // a command completes when its wake returns to sleep
  always_ff @(posedge clk) begin
    if (srst || state == LSMS_OFF) begin
      cmd_done <= 1'b0;
    end else if (cmd_write && in_standby && cmd_code != CMD_NOP) begin
      cmd_done <= 1'b1;
    end else if (in_standby && todo_prox == 3'h0 && todo_amb == 3'h0) begin
      cmd_done <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state == LSMS_OFF) begin
      response <= {4'h0, RESP_RESET};
    end else if (cmd_write && in_standby && cmd_code == CMD_NOP) begin
      response <= 8'h00;
    end else if (cmd_done && in_standby && todo_prox == 3'h0 && todo_amb == 3'h0) begin
      response <= {4'h0, response[3:0] + 4'h1};
    end
  end

  // interrupt: set wins over clear, level held through standby
  always_ff @(posedge clk) begin
    if (srst || state == LSMS_OFF) begin
      irq_pend <= 1'b0;
    end else if (busy && conv_done.done &&
                 ((busy_chan < 3'h4 && prox_irq_enable) || (busy_chan >= 3'h4 && amb_irq_enable))) begin
      irq_pend <= 1'b1;
    end else if (irq_clear) begin
      irq_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      unlocked <= 1'b0;
    end else begin
      unlocked <= unlock_code_reg == UNLOCK_KEY_VALUE;
    end
  end

  assign irq_o = 1'b0;
  assign irq_oe = irq_pend;
  assign mode = state;
  assign regs_ready = state != LSMS_OFF && state != LSMS_INIT;

  // reset walk: one cycle in off, then initialization
  sequence s_reset_walk;
    state == LSMS_OFF ##1 state == LSMS_INIT;
  endsequence

  a_standby_idle: assert property (@(posedge clk) disable iff (srst)
    in_standby |-> !busy) else $error("conversion while asleep");
  a_off_to_init: assert property (@(posedge clk) disable iff (srst)
    (bus_reset || soft_reset) |=> s_reset_walk) else $error("reset path");
  a_irq_hold: assert property (@(posedge clk) disable iff (srst)
    (irq_pend && !irq_clear && state != LSMS_OFF && !bus_reset && !soft_reset) |=> irq_pend)
    else $error("irq dropped");
  a_prox_order: assert property (@(posedge clk) disable iff (srst)
    (conv_req.valid && conv_req.chan >= 3'h4) |-> todo_prox == 3'h0) else $error("ambient before proximity");
  a_forced_quiet: assert property (@(posedge clk) disable iff (srst)
    (in_standby && wake_interval == 8'h00 && !cmd_write && todo_prox == 3'h0 && todo_amb == 3'h0)
    |=> (todo_prox == 3'h0 && todo_amb == 3'h0)) else $error("periodic wake in forced");
  a_result_upd: assert property (@(posedge clk) disable iff (srst)
    (busy && conv_done.done) |=> result[$past(busy_chan)] == $past(conv_done.data)) else $error("result stale");
  a_irq_gate: assert property (@(posedge clk) disable iff (srst)
    (!irq_pend && !prox_irq_enable && !amb_irq_enable && state != LSMS_OFF) |=> !irq_pend)
    else $error("irq without enable");
  a_idle_wake: assert property (@(posedge clk) disable iff (srst)
    (in_standby && !cmd_write && !wake_periodic && todo_prox == 3'h0 && todo_amb == 3'h0 && !bus_reset)
    |=> in_standby) else $error("woke without cause");
  a_init_exit: assert property (@(posedge clk) disable iff (srst)
    (state == LSMS_INIT && init_cnt == INIT_W'(INIT_CYCLES_P - 1) && !bus_reset && !soft_reset)
    |=> in_standby) else $error("init did not end");
  a_loop_arm: assert property (@(posedge clk) disable iff (srst)
    (cmd_write && in_standby && cmd_code == CMD_LOOP_BOTH && !bus_reset) |=> (loop_prox && loop_amb))
    else $error("loop not armed");
  a_nop_clear: assert property (@(posedge clk) disable iff (srst)
    (cmd_write && in_standby && cmd_code == CMD_NOP) |=> response == 8'h00) else $error("response not cleared");
  a_sleep_quiet: assert property (@(posedge clk) disable iff (srst)
    conv_req.valid |-> !in_standby) else $error("request while asleep");
endmodule // lsms_sequencer
